// ==== hw/codec_power_cp_status_regs.sv ====
// What this block does
// RULE1: Right preamp gain field, 1dB steps, 0x00=-1dB to 0x25=36dB, resets 0x00.
// RULE2: Left and right preamp power enables, reset off, set powers preamp.
// RULE3: Two-bit integrator power enable, bit0 left, bit1 right, reset off.
// RULE4: Host should enable driver input stages before main drivers to limit pop.
// RULE5: Two-bit main driver power enable, bit0 left, bit1 right, reset off.
// RULE6: Bit clock, frame sync, ADC data pad strength selects, reset normal.
// RULE7: Control data pad strength select resets to stronger, zero gives normal.
// RULE8: Two-bit DAC power-down-bar, 00 off, 11 on, resets to 11.
// RULE9: Charge pump enable bit, reset off, one turns the pump on.
// RULE10: Positive rail pos_rail_en_a enable, reset off, speeds pump startup.
// RULE11: Independent negative and positive pad discharge enables, reset off.
// RULE12: Two charge-up current limit selects, reset low, one selects high.
// RULE13: Two force bits push pump clock to fast rate, reset off.
// RULE14: Monitor register shows short-circuit emergency shutdown flag.
// RULE15: Read-only live charge pump enable state, 0 off, 1 on.
// RULE16: Read-only DC draw bit, 0 drawing, 1 not drawing.
// RULE17: Read-only positive rail status, 0 possible short, 1 normal maximum.
// RULE18: Read-only pump frequency status, 0 normal, 1 maximum.
// RULE19: Read-only low-voltage low-current status, 0 no current, 1 current.
// RULE20: Host writes one to momentary clear bit; it self-clears and reads zero.
// RULE21: Writes to monitor and general status registers are ignored.
`timescale 1ns/1ps
`include "codec_power_regs.svh"
module codec_power_cp_status_regs #(
	parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary bus address
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic scl,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire codec_power_pkg::cp_monitor_t cp_monitor_raw,
	input wire logic [15:0] status_raw,
	output logic [5:0] right_preamp_gain,
	output codec_power_pkg::power_ctrl_t power_ctrl,
	output codec_power_pkg::cp_ctrl_t cp_ctrl,
	output logic short_shutdown_clear,
	output logic short_shutdown_flag
);
	logic scl_s;
	logic sda_s;
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic start_det;
	logic stop_det;
	codec_power_pkg::serial_state_t state;
	logic [3:0] bit_cnt;
	logic [7:0] shift;
	logic [2:0] phase;
	logic rw;
	logic acked;
	logic tx_lo;
	logic [15:0] reg_addr;
	logic [7:0] data_hi;
	logic [15:0] tx_word;
	logic [15:0] rd_word;
	logic wr_stb;
	logic [15:0] wr_addr;
	logic [15:0] wr_data;
	codec_power_pkg::cp_monitor_t mon_s;
	logic [15:0] status_s;
	logic [5:0] next_gain;

	// Pins and analog monitors come from other domains
	sync_bits #(
		.WIDTH(2),
		.RESET_VALUE(2'b11)
	) u_pin_sync (
		.clk(clk),
		.nrst(nrst),
		.d({scl, sda_in}),
		.q({scl_s, sda_s})
	);

	sync_bits #(
		.WIDTH(7),
		.RESET_VALUE(`RST_CP_MON)
	) u_mon_sync (
		.clk(clk),
		.nrst(nrst),
		.d(cp_monitor_raw),
		.q(mon_s)
	);

	sync_bits #(
		.WIDTH(16),
		.RESET_VALUE(`RST_STATUS)
	) u_status_sync (
		.clk(clk),
		.nrst(nrst),
		.d(status_raw),
		.q(status_s)
	);

	sticky_flag u_short_flag (
		.clk(clk),
		.nrst(nrst),
		.set(mon_s.short_event),
		.clear(short_shutdown_clear),
		.flag(short_shutdown_flag)
	);

	always_ff @(posedge clk) begin
		if (!nrst) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	assign scl_rise = scl_s & ~scl_d;
	assign scl_fall = ~scl_s & scl_d;
	assign start_det = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

	// Read side: live monitor bits 5:0, with the stored short flag in bit 6
	always_comb begin
		rd_word = 16'h0000;
		case (reg_addr)
			`REG_GAIN_R: rd_word = {10'h000, right_preamp_gain};
			`REG_POWER: rd_word = {8'h00, power_ctrl};
			`REG_CP_CTRL: rd_word = cp_ctrl & `CP_CTRL_WMASK;
			`REG_CP_MON: rd_word = {9'h000, short_shutdown_flag, mon_s[`MON_LIVE_MSB:0]}; // RULE14
			`REG_STATUS: rd_word = status_s;
			default: rd_word = 16'h0000;
		endcase
	end

	// Open-drain: only ever pulls low
	always_ff @(posedge clk) begin
		if (!nrst) begin
			sda_out <= 1'b0;
		end else begin
			sda_out <= 1'b0;
		end
	end

	// Serial frame engine: sample on SCL rise, change SDA on SCL fall
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state <= codec_power_pkg::st_idle;
			bit_cnt <= 4'h0;
			shift <= 8'h00;
			phase <= `PH_DEV;
			rw <= 1'b0;
			acked <= 1'b0;
			tx_lo <= 1'b0;
			reg_addr <= 16'h0000;
			data_hi <= 8'h00;
			tx_word <= 16'h0000;
			sda_oe <= 1'b0;
			wr_stb <= 1'b0;
			wr_addr <= 16'h0000;
			wr_data <= 16'h0000;
		end else begin
			wr_stb <= 1'b0;
			if (start_det) begin
				state <= codec_power_pkg::st_rx;
				bit_cnt <= 4'h0;
				phase <= `PH_DEV;
				sda_oe <= 1'b0;
			end else if (stop_det) begin
				state <= codec_power_pkg::st_idle;
				sda_oe <= 1'b0;
			end else begin
				case (state)
					codec_power_pkg::st_idle: begin
						sda_oe <= 1'b0;
					end
					codec_power_pkg::st_rx: begin
						if (scl_rise && bit_cnt < `BITS_PER_BYTE) begin
							shift <= {shift[6:0], sda_s};
							bit_cnt <= bit_cnt + 4'h1;
						end else if (scl_fall && bit_cnt == `BITS_PER_BYTE) begin
							sda_oe <= 1'b1;
							state <= codec_power_pkg::st_ack;
							phase <= (phase == `PH_DATA_LO) ? `PH_DATA_HI : phase + 3'h1;
							case (phase)
								`PH_DEV: begin
									if (shift[7:1] == DEV_ADDR) begin
										rw <= shift[0];
										tx_word <= rd_word;
									end else begin
										sda_oe <= 1'b0;
										state <= codec_power_pkg::st_idle;
									end
								end
								`PH_IDX_HI: reg_addr[15:8] <= shift;
								`PH_IDX_LO: reg_addr[7:0] <= shift;
								`PH_DATA_HI: data_hi <= shift;
								`PH_DATA_LO: begin
									wr_stb <= 1'b1;
									wr_addr <= reg_addr;
									wr_data <= {data_hi, shift};
									reg_addr <= reg_addr + 16'h0001;
								end
								default: begin
									sda_oe <= 1'b0;
									state <= codec_power_pkg::st_idle;
								end
							endcase
						end
					end
					codec_power_pkg::st_ack: begin
						if (scl_fall) begin
							bit_cnt <= 4'h0;
							if (rw && phase == `PH_IDX_HI) begin
								state <= codec_power_pkg::st_tx;
								tx_lo <= 1'b0;
								sda_oe <= ~tx_word[15];
							end else begin
								state <= codec_power_pkg::st_rx;
								sda_oe <= 1'b0;
							end
						end
					end
					codec_power_pkg::st_tx: begin
						if (scl_fall) begin
							tx_word <= {tx_word[14:0], 1'b0};
							if (bit_cnt == `LAST_TX_BIT) begin
								sda_oe <= 1'b0;
								state <= codec_power_pkg::st_rack;
							end else begin
								sda_oe <= ~tx_word[14];
								bit_cnt <= bit_cnt + 4'h1;
							end
						end
					end
					codec_power_pkg::st_rack: begin
						if (scl_rise) begin
							acked <= ~sda_s;
							if (tx_lo) begin
								reg_addr <= reg_addr + 16'h0001;
							end
						end else if (scl_fall) begin
							bit_cnt <= 4'h0;
							if (acked) begin
								state <= codec_power_pkg::st_tx;
								tx_lo <= ~tx_lo;
								if (tx_lo) begin
									tx_word <= rd_word;
									sda_oe <= ~rd_word[15];
								end else begin
									sda_oe <= ~tx_word[15];
								end
							end else begin
								state <= codec_power_pkg::st_idle;
							end
						end
					end
					default: begin
						sda_oe <= 1'b0;
						state <= codec_power_pkg::st_idle;
					end
				endcase
			end
		end
	end

	// Codes above 36dB saturate rather than wrap
	always_comb begin
		next_gain = wr_data[`GAIN_R_MSB:0];
		if (wr_data[`GAIN_R_MSB:0] > `GAIN_R_MAX) begin
			next_gain = `GAIN_R_MAX;
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			right_preamp_gain <= `RST_GAIN_R; // RULE1
		end else if (wr_stb && wr_addr == `REG_GAIN_R) begin
			right_preamp_gain <= next_gain; // RULE1
		end
	end

	// Pop ordering is left to the host; no interlock here
	always_ff @(posedge clk) begin
		if (!nrst) begin
			power_ctrl <= `RST_POWER; // RULE2 RULE3 RULE5
		end else if (wr_stb && wr_addr == `REG_POWER) begin
			power_ctrl <= wr_data[`POWER_MSB:0]; // RULE2 RULE3 RULE5
		end
	end

	// Reserved bits are never stored, so they read back zero
	always_ff @(posedge clk) begin
		if (!nrst) begin
			cp_ctrl <= `RST_CP_CTRL; // RULE6 RULE7 RULE8
		end else if (wr_stb && wr_addr == `REG_CP_CTRL) begin
			cp_ctrl <= wr_data & `CP_CTRL_WMASK; // RULE9 RULE10 RULE11 RULE12 RULE13
		end
	end

	// Momentary clear: one-cycle pulse, reads back zero
	always_ff @(posedge clk) begin
		if (!nrst) begin
			short_shutdown_clear <= 1'b0;
		end else begin
			short_shutdown_clear <= wr_stb && wr_addr == `REG_SHORT_CLR
				&& wr_data[`SHORT_CLR_BIT]; // RULE20
		end
	end

	// Monitor and status indices have no write path at all
	// RULE15 RULE16 RULE17 RULE18 RULE19 RULE21

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	sequence write_to(logic [15:0] idx);
		wr_stb && wr_addr == idx;
	endsequence

	sequence clear_written;
		write_to(`REG_SHORT_CLR) ##0 wr_data[`SHORT_CLR_BIT];
	endsequence

	gain_range_a: assert property (right_preamp_gain <= `GAIN_R_MAX) // RULE1
		else $error("right gain beyond 36dB code");
	gain_write_a: assert property (write_to(`REG_GAIN_R) |=> // RULE1
		right_preamp_gain == (($past(wr_data[5:0]) > `GAIN_R_MAX) ? `GAIN_R_MAX
		: $past(wr_data[5:0])))
		else $error("right gain write not taken");
	power_reset_a: assert property (@(posedge clk) disable iff (1'b0) // RULE2
		!nrst |=> power_ctrl == `RST_POWER && right_preamp_gain == `RST_GAIN_R)
		else $error("power enables not off after reset");
	cp_reset_a: assert property (@(posedge clk) disable iff (1'b0) // RULE8
		!nrst |=> cp_ctrl == `RST_CP_CTRL && cp_ctrl.dac_power_down_bar == 2'b11
		&& cp_ctrl.ctrl_data_pad_strength && !cp_ctrl.cp_enable)
		else $error("charge pump control reset wrong");
	pump_enable_a: assert property (write_to(`REG_CP_CTRL) |=> // RULE9
		cp_ctrl.cp_enable == $past(wr_data[5]) && !cp_ctrl.reserved_hi)
		else $error("pump enable write not taken");
	clear_pulse_a: assert property (clear_written |=> short_shutdown_clear // RULE20
		##1 !short_shutdown_clear)
		else $error("clear bit not momentary");
	ro_ignored_a: assert property ((write_to(`REG_CP_MON) or write_to(`REG_STATUS)) // RULE21
		|=> $stable(cp_ctrl) && $stable(power_ctrl) && $stable(right_preamp_gain))
		else $error("read-only write changed state");
	monitor_read_a: assert property (reg_addr == `REG_CP_MON |-> // RULE15
		rd_word[3] == mon_s.cp_enable_status && rd_word[4] == mon_s.cp_dc_draw_status
		&& rd_word[`MON_FLAG_BIT] == short_shutdown_flag)
		else $error("monitor word does not show live state");
	write_pair_a: assert property (write_to(`REG_POWER) |=> // RULE5
		power_ctrl.main_driver_en == $past(wr_data[1:0])
		&& power_ctrl.integrator_power_en == $past(wr_data[5:4]))
		else $error("driver enable write not taken");
endmodule : codec_power_cp_status_regs

// ==== hw/sticky_flag.sv ====
`timescale 1ns/1ps
module sticky_flag (
	input wire logic clk,
	input wire logic nrst,
	input wire logic set,
	input wire logic clear,
	output logic flag
);
	// Set beats clear so an event in the clear cycle survives
	always_ff @(posedge clk) begin
		if (!nrst) begin
			flag <= 1'b0;
		end else if (set) begin
			flag <= 1'b1; // RULE14
		end else if (clear) begin
			flag <= 1'b0; // RULE20
		end
	end

	flag_set_a: assert property (@(posedge clk) disable iff (!nrst) set |=> flag) // RULE14
		else $error("shutdown flag missed its event");
	flag_clear_a: assert property (@(posedge clk) disable iff (!nrst) // RULE20
		clear && !set |=> !flag)
		else $error("shutdown flag not cleared");
	flag_hold_a: assert property (@(posedge clk) disable iff (!nrst) // RULE14
		flag && !clear |=> flag)
		else $error("shutdown flag dropped without clear");
endmodule : sticky_flag

// ==== hw/sync_bits.sv ====
`timescale 1ns/1ps
module sync_bits #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage1;

	// First stage feeds only the second stage
	always_ff @(posedge clk) begin
		if (!nrst) begin
			stage1 <= RESET_VALUE;
			q <= RESET_VALUE;
		end else begin
			stage1 <= d;
			q <= stage1;
		end
	end
endmodule : sync_bits

// ==== shared/codec_power_pkg.sv ====
package codec_power_pkg;

	typedef struct packed {
		logic left_preamp_power_en;
		logic right_preamp_power_en;
		logic [1:0] integrator_power_en;
		logic [1:0] driver_input_stage_en;
		logic [1:0] main_driver_en;
	} power_ctrl_t;

	typedef struct packed {
		logic reserved_hi;
		logic bitclk_pad_strength;
		logic framesync_pad_strength;
		logic adc_data_pad_strength;
		logic ctrl_data_pad_strength;
		logic reserved_mid;
		logic [1:0] dac_power_down_bar;
		logic cp_fast_clock_force_b;
		logic cp_fast_clock_force_a;
		logic cp_enable;
		logic pos_rail_en_a;
		logic neg_pad_discharge_en;
		logic pos_pad_discharge_en;
		logic charge_limit_sel_b;
		logic charge_limit_sel_a;
	} cp_ctrl_t;

	typedef struct packed {
		logic short_event;
		logic cp_mode1_status;
		logic cp_dc_draw_status;
		logic cp_enable_status;
		logic positive_rail_high;
		logic cp_low_current_status;
		logic cp_frequency_status;
	} cp_monitor_t;

	typedef enum logic [2:0] {
		st_idle,
		st_rx,
		st_ack,
		st_tx,
		st_rack
	} serial_state_t;

endpackage : codec_power_pkg

// ==== shared/codec_power_regs.svh ====
`ifndef CODEC_POWER_REGS_SVH
`define CODEC_POWER_REGS_SVH

// Register indices on the control serial port (16-bit index, 16-bit data)
`define REG_SHORT_CLR 16'h0076
`define REG_GAIN_R 16'h007e
`define REG_POWER 16'h007f
`define REG_CP_CTRL 16'h0080
`define REG_CP_MON 16'h0081
`define REG_STATUS 16'h0082

// Reset values
`define RST_GAIN_R 6'h00
`define RST_POWER 8'h00
`define RST_CP_CTRL 16'h0b00
`define RST_CP_MON 7'h13
`define RST_STATUS 16'h0020

// Field positions and masks
`define GAIN_R_MSB 5
`define GAIN_R_MAX 6'h25
`define POWER_MSB 7
`define CP_CTRL_WMASK 16'h7bff
`define SHORT_CLR_BIT 15
`define MON_FLAG_BIT 6
`define MON_LIVE_MSB 5

// Serial frame layout
`define BITS_PER_BYTE 4'h8
`define LAST_TX_BIT 4'h7
`define PH_DEV 3'h0
`define PH_IDX_HI 3'h1
`define PH_IDX_LO 3'h2
`define PH_DATA_HI 3'h3
`define PH_DATA_LO 3'h4

`endif

// ==== testbench/codec_power_cp_status_regs_tb.sv ====
`timescale 1ns/1ps
`include "codec_power_regs.svh"
module codec_power_cp_status_regs_tb;
	localparam logic [6:0] ADDR = 7'h2a;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic scl;
	logic sda_pull;
	logic sda_out;
	logic sda_oe;
	logic sda;
	codec_power_pkg::cp_monitor_t cp_monitor_raw = 7'h13;
	logic [15:0] status_raw = 16'h0020;
	logic [5:0] right_preamp_gain;
	codec_power_pkg::power_ctrl_t power_ctrl;
	codec_power_pkg::cp_ctrl_t cp_ctrl;
	logic short_shutdown_clear;
	logic short_shutdown_flag;
	int fail_count = 0;
	int compares = 0;
	int cycles = 0;
	int pulses = 0;
	// Open drain with pull-up
	assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_pull;
	always #2 clk = ~clk;
	host_model u_host (.clk(clk), .sda(sda), .scl(scl), .sda_pull(sda_pull));
	codec_power_cp_status_regs #(.DEV_ADDR(ADDR)) u_dut (
		.clk(clk), .nrst(nrst), .scl(scl), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .cp_monitor_raw(cp_monitor_raw), .status_raw(status_raw),
		.right_preamp_gain(right_preamp_gain), .power_ctrl(power_ctrl), .cp_ctrl(cp_ctrl),
		.short_shutdown_clear(short_shutdown_clear),
		.short_shutdown_flag(short_shutdown_flag)
	);
	task automatic wrap_up();
		$display("Mismatches %0d, comparisons %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrap_up
	always @(posedge clk) begin
		cycles++;
		if (short_shutdown_clear === 1'b1) pulses++;
		if (cycles == 90000) begin
			fail_count++;
			wrap_up();
		end
	end
	task automatic check_word(input string what, input logic [15:0] e, input logic [15:0] g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask : check_word
	task automatic check_bit(input string what, input logic e, input logic g);
		compares++;
		if (g !== e) begin
			fail_count++;
			$display("Error %s expected %b seen %b", what, e, g);
		end
	endtask : check_bit
	task automatic write_reg(input logic [15:0] idx, input logic [15:0] d);
		logic [39:0] bytes;
		logic a;
		bytes = {ADDR, 1'b0, idx, d};
		u_host.start();
		for (int i = 4; i >= 0; i--) begin
			u_host.put_byte(bytes[i*8 +: 8], a);
			check_bit("write ack", 1'b1, a);
		end
		u_host.stop();
	endtask : write_reg
	task automatic expect_reg(input logic [15:0] idx, input logic [15:0] e);
		logic [15:0] d;
		logic a0, a1, a2, a3;
		u_host.start();
		u_host.put_byte({ADDR, 1'b0}, a0);
		u_host.put_byte(idx[15:8], a1);
		u_host.put_byte(idx[7:0], a2);
		u_host.start();
		u_host.put_byte({ADDR, 1'b1}, a3);
		u_host.get_byte(1'b0, d[15:8]);
		u_host.get_byte(1'b1, d[7:0]);
		u_host.stop();
		check_bit("read acks", 1'b1, a0 & a1 & a2 & a3);
		check_word("register read", e, d);
	endtask : expect_reg
	task automatic test_reset();
		expect_reg(`REG_GAIN_R, 16'h0000);
		expect_reg(`REG_POWER, 16'h0000);
		expect_reg(`REG_CP_CTRL, 16'h0b00);
		check_word("cp_ctrl port", 16'h0b00, cp_ctrl);
		expect_reg(`REG_CP_MON, 16'h0013);
		expect_reg(`REG_STATUS, 16'h0020);
		expect_reg(`REG_SHORT_CLR, 16'h0000);
	endtask : test_reset
	task automatic test_gain();
		logic [15:0] codes [4];
		logic [15:0] e;
		codes = '{16'h0025, 16'h0001, 16'h0026, 16'h003f};
		foreach (codes[i]) begin
			e = (codes[i] > 16'h0025) ? 16'h0025 : codes[i];
			write_reg(`REG_GAIN_R, codes[i]);
			expect_reg(`REG_GAIN_R, e);
			check_word("gain port", e, {10'h000, right_preamp_gain});
		end
	endtask : test_gain
	task automatic test_power();
		write_reg(`REG_POWER, 16'h000c);
		check_word("input stage", 16'h0003, {14'h0000, power_ctrl.driver_input_stage_en});
		write_reg(`REG_POWER, 16'h000f);
		check_word("main driver", 16'h0003, {14'h0000, power_ctrl.main_driver_en});
		write_reg(`REG_POWER, 16'h0061);
		expect_reg(`REG_POWER, 16'h0061);
		check_bit("left preamp", 1'b0, power_ctrl.left_preamp_power_en);
		check_bit("right preamp", 1'b1, power_ctrl.right_preamp_power_en);
		check_word("integrator", 16'h0002, {14'h0000, power_ctrl.integrator_power_en});
		check_word("main left", 16'h0001, {14'h0000, power_ctrl.main_driver_en});
	endtask : test_power
	task automatic test_cp_ctrl();
		logic [15:0] d;
		// Reserved bits 15 and 10 must stay clear
		for (int i = 0; i < 16; i++) begin
			d = 16'h0001 << i;
			write_reg(`REG_CP_CTRL, d);
			expect_reg(`REG_CP_CTRL, d & 16'h7bff);
			check_word("cp_ctrl port", d & 16'h7bff, cp_ctrl);
			check_bit("cp_enable", i == 5, cp_ctrl.cp_enable);
		end
		write_reg(`REG_CP_CTRL, 16'h0300);
		check_word("dac enable", 16'h0003, {14'h0000, cp_ctrl.dac_power_down_bar});
	endtask : test_cp_ctrl
	task automatic test_monitor();
		cp_monitor_raw = 7'h2c;
		status_raw = 16'ha5c3;
		repeat (8) @(negedge clk);
		expect_reg(`REG_CP_MON, 16'h002c);
		write_reg(`REG_CP_MON, 16'hffff);
		write_reg(`REG_STATUS, 16'h0000);
		expect_reg(`REG_CP_MON, 16'h002c);
		expect_reg(`REG_STATUS, 16'ha5c3);
		cp_monitor_raw.short_event = 1'b1;
		repeat (8) @(negedge clk);
		cp_monitor_raw.short_event = 1'b0;
		repeat (8) @(negedge clk);
		check_bit("short flag", 1'b1, short_shutdown_flag);
		expect_reg(`REG_CP_MON, 16'h006c);
		pulses = 0;
		write_reg(`REG_SHORT_CLR, 16'h8000);
		repeat (8) @(negedge clk);
		check_word("clear pulses", 16'h0001, pulses[15:0]);
		check_bit("short flag", 1'b0, short_shutdown_flag);
		expect_reg(`REG_SHORT_CLR, 16'h0000);
		expect_reg(`REG_CP_MON, 16'h002c);
	endtask : test_monitor
	task automatic test_refuse();
		logic a;
		expect_reg(16'h0010, 16'h0000);
		u_host.start();
		u_host.put_byte({ADDR ^ 7'h01, 1'b0}, a);
		u_host.stop();
		check_bit("foreign address ack", 1'b0, a);
		expect_reg(`REG_GAIN_R, 16'h0025);
	endtask : test_refuse
	// Two-word bursts exercise index auto-increment on both directions
	task automatic test_burst();
		logic [7:0] frame [7];
		logic [15:0] d0;
		logic [15:0] d1;
		logic a;
		frame = '{{ADDR, 1'b0}, 8'h00, 8'h7e, 8'h00, 8'h12, 8'h00, 8'ha4};
		u_host.start();
		foreach (frame[i]) begin
			u_host.put_byte(frame[i], a);
			check_bit("burst write ack", 1'b1, a);
		end
		u_host.stop();
		check_word("burst gain", 16'h0012, {10'h000, right_preamp_gain});
		check_word("burst power", 16'h00a4, {8'h00, power_ctrl});
		u_host.start();
		u_host.put_byte({ADDR, 1'b0}, a);
		u_host.put_byte(8'h00, a);
		u_host.put_byte(8'h7e, a);
		u_host.start();
		u_host.put_byte({ADDR, 1'b1}, a);
		u_host.get_byte(1'b0, d0[15:8]);
		u_host.get_byte(1'b0, d0[7:0]);
		u_host.get_byte(1'b0, d1[15:8]);
		u_host.get_byte(1'b1, d1[7:0]);
		u_host.stop();
		check_word("burst read first", 16'h0012, d0);
		check_word("burst read second", 16'h00a4, d1);
	endtask : test_burst
	// Reset in mid-run must bring every control back to its default
	task automatic test_rerun_reset();
		nrst = 1'b0;
		repeat (5) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		check_word("reset gain", 16'h0000, {10'h000, right_preamp_gain});
		check_word("reset power", 16'h0000, {8'h00, power_ctrl});
		check_word("reset cp_ctrl", 16'h0b00, cp_ctrl);
		check_bit("reset flag", 1'b0, short_shutdown_flag);
		expect_reg(`REG_GAIN_R, 16'h0000);
	endtask : test_rerun_reset
	initial begin
		repeat (5) @(negedge clk);
		nrst = 1'b1;
		repeat (4) @(negedge clk);
		test_reset();
		test_gain();
		test_power();
		test_cp_ctrl();
		test_monitor();
		test_refuse();
		test_burst();
		test_rerun_reset();
		wrap_up();
	end
endmodule : codec_power_cp_status_regs_tb

// ==== testbench/host_model.sv ====
`timescale 1ns/1ps
module host_model (
	input wire logic clk,
	input wire logic sda,
	output logic scl,
	output logic sda_pull
);
	initial begin
		scl = 1'b1;
		sda_pull = 1'b0;
	end
	task automatic half();
		repeat (8) @(negedge clk);
	endtask : half
	// Data settles two cycles after scl falls, never with the edge
	task automatic settle();
		repeat (2) @(negedge clk);
	endtask : settle
	// Also serves as repeated start
	task automatic start();
		sda_pull = 1'b0;
		half();
		scl = 1'b1;
		half();
		sda_pull = 1'b1;
		half();
		scl = 1'b0;
		settle();
	endtask : start
	task automatic stop();
		sda_pull = 1'b1;
		half();
		scl = 1'b1;
		half();
		sda_pull = 1'b0;
		half();
	endtask : stop
	task automatic clock_bit(input logic b, output logic seen);
		sda_pull = ~b;
		half();
		scl = 1'b1;
		half();
		seen = sda;
		scl = 1'b0;
		settle();
	endtask : clock_bit
	task automatic put_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) clock_bit(d[i], s);
		clock_bit(1'b1, s);
		ack = ~s;
	endtask : put_byte
	task automatic get_byte(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) clock_bit(1'b1, d[i]);
		clock_bit(last, s);
	endtask : get_byte
endmodule : host_model
